// [inc/clk_ctrl_pkg.sv]
/*
  Package for the system clock start-up control block: register map,
  field positions, reset values, cycle counts, states and carriers.
  Assumes a classic Wishbone slave with 8-bit data in the low byte lane.
*/
package clk_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_BREAK_STATUS  = 16'hfe00;
  localparam logic [15:0] ADDR_RESET_CAUSE   = 16'hfe01;
  localparam logic [15:0] ADDR_BREAK_CONTROL = 16'hfe03;
  localparam logic [15:0] ADDR_CONFIG        = 16'hfe04;
  localparam logic [15:0] ADDR_IRQ_STATUS    = 16'hfe08;
  localparam logic [15:0] ADDR_IRQ_MASK      = 16'hfe0c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_POWER_ON    = 7;
  localparam int BIT_PIN         = 6;
  localparam int BIT_WATCHDOG    = 5;
  localparam int BIT_BAD_OPCODE  = 4;
  localparam int BIT_BAD_ADDRESS = 3;
  localparam int BIT_LOW_VOLTAGE = 1;
  localparam int BIT_BREAK_WAIT  = 1;
  localparam int BIT_CLEAR_EN    = 7;
  localparam int BIT_SHORT_STOP  = 0;
  localparam int BIT_CFG_WAIT_ACT = 1;
  localparam int BIT_IRQ_START   = 0;
  localparam int BIT_IRQ_STOPEX  = 1;
  localparam int BIT_IRQ_CAUSE   = 2;

  localparam logic [7:0] CAUSE_MASK = 8'hfa;
  localparam logic [7:0] IRQ_MASK   = 8'h07;
  localparam logic [7:0] CFG_MASK   = 8'h03;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam int          STAB_WIDTH      = 12;
  localparam logic [11:0] LONG_DELAY      = 12'hfff; // 4096 cycles
  localparam logic [11:0] SHORT_DELAY     = 12'h01f; // 32 cycles
  localparam int          BUS_DIVIDE      = 2;
  localparam int          IRQ_SOURCES     = 32;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_STARTUP = 4'b0001,
    ST_RUN     = 4'b0010,
    ST_STOP    = 4'b0100,
    ST_RECOVER = 4'b1000
  } clk_state_e;

  // Reset sources reported by the rest of the chip
  typedef struct packed {
    logic power_on;
    logic pin;
    logic watchdog;
    logic bad_opcode;
    logic bad_address;
    logic low_voltage;
  } reset_src_s;

  // Gated clock enables toward core and modules
  typedef struct packed {
    logic cpu;
    logic periph;
  } clk_en_s;

endpackage : clk_ctrl_pkg

// [rtl/system_clock_startup_control.sv]
/*
  System clock start-up control: bus clock enable generation from the
  clock generator output, start-up and stop-recovery timeouts, wait mode
  gating, reset cause and break registers, and an event interrupt.
  Assumes mclk is the clock generator output and osc_ref_tick is a
  one-cycle enable marking each falling edge of the oscillator reference.
*/
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/10ps
module system_clock_startup_control #(
  parameter int          STARTUP_CYCLES = 4096,
  parameter int          IRQ_COUNT      = clk_ctrl_pkg::IRQ_SOURCES
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     arst_n,
  // Reference tick and reset sources
  input  wire logic                     osc_ref_tick,
  input  wire clk_ctrl_pkg::reset_src_s reset_src,
  // Power mode requests from the core and the events that end them
  input  wire logic                     stop_req,
  input  wire logic                     wait_req,
  input  wire logic                     wake_event,
  input  wire logic                     break_event,
  input  wire logic [IRQ_COUNT-1:0]     irq_sources,
  // Wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [15:0]              wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // Clock enables and pins
  output clk_ctrl_pkg::clk_en_s         clk_en,
  output logic                          bus_clk_en,
  output logic                          reset_out,
  output logic                          reset_oe_n,
  output logic                          irq_pending,
  output logic                          irq_out
);
  import clk_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  clk_state_e           state;
  clk_state_e           next_state;
  logic [STAB_WIDTH-1:0] stab_count;
  logic                 bus_div;
  logic                 in_wait;
  logic [7:0]           reset_cause;
  logic                 break_wait;
  logic                 clear_enable;
  logic [7:0]           config_reg;
  logic [7:0]           irq_status;
  logic [7:0]           irq_mask;

  localparam logic [STAB_WIDTH-1:0] STARTUP_LAST =
    STAB_WIDTH'(STARTUP_CYCLES - 1);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire       bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wr_lane0  = bus_req & wb_we_i & wb_sel_i[0];
  wire       hit_brk   = wb_adr_i == ADDR_BREAK_STATUS;
  wire       hit_cause = wb_adr_i == ADDR_RESET_CAUSE;
  wire       hit_ctl   = wb_adr_i == ADDR_BREAK_CONTROL;
  wire       hit_cfg   = wb_adr_i == ADDR_CONFIG;
  wire       hit_ist   = wb_adr_i == ADDR_IRQ_STATUS;
  wire       hit_imk   = wb_adr_i == ADDR_IRQ_MASK;
  wire [7:0] wr_byte   = wb_dat_i[7:0];

  // Reserved bits read as zero; unmapped addresses read zero with ack
  wire [7:0] rd_byte =
    hit_brk   ? {6'h00, break_wait, 1'b0}        :
    hit_cause ? (reset_cause & CAUSE_MASK)        :
    hit_ctl   ? {clear_enable, 7'h00}            :
    hit_cfg   ? (config_reg & CFG_MASK)           :
    hit_ist   ? irq_status                        :
    hit_imk   ? irq_mask                          : 8'h00;

  // ----------------------------------------------------------------
  // Timeout decode
  // ----------------------------------------------------------------
  wire short_stop = config_reg[BIT_SHORT_STOP];
  // Short recovery suits canned oscillators; crystals need the long one
  wire [STAB_WIDTH-1:0] stop_last =
    short_stop ? SHORT_DELAY : LONG_DELAY;
  wire startup_done  = osc_ref_tick & (stab_count == STARTUP_LAST);
  wire recover_done  = osc_ref_tick & (stab_count == stop_last);
  wire por_event     = reset_src.power_on | reset_src.low_voltage;
  wire stop_exit     = wake_event | break_event;
  wire any_irq       = |irq_sources;
  wire clocks_run    = state == ST_RUN;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_STARTUP: begin
        if (startup_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (por_event) begin
          next_state = ST_STARTUP;
        end else if (stop_req) begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (por_event) begin
          next_state = ST_STARTUP;
        end else if (stop_exit | any_irq | reset_src.pin) begin
          next_state = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (por_event) begin
          next_state = ST_STARTUP;
        end else if (recover_done) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_STARTUP;
    endcase
  end

  // ----------------------------------------------------------------
  // State register and stabilization counter
  // ----------------------------------------------------------------
  // Counter advances only on reference falling-edge ticks
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_STARTUP;
      stab_count <= '0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        stab_count <= '0;
      end else if (osc_ref_tick && !clocks_run && state != ST_STOP) begin
        stab_count <= stab_count + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus clock divider: generator output halved
  // ----------------------------------------------------------------
  // Divider clears to zero while clocks are held so the restart phase is known
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus_div <= 1'b0;
    end else if (clocks_run) begin
      bus_div <= ~bus_div;
    end else begin
      bus_div <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Wait mode tracking
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      in_wait <= 1'b0;
    end else if (!clocks_run || stop_exit || any_irq) begin
      in_wait <= 1'b0;
    end else if (wait_req) begin
      in_wait <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Clock enable outputs
  // ----------------------------------------------------------------
  // All enables derive from the one generator clock, mclk
  // Dropped in the leaving cycle so no pulse escapes into a held phase
  wire next_bus_en = clocks_run & (next_state == ST_RUN)
    & ~bus_div;
  wire next_cpu_en = next_bus_en & ~in_wait;
  wire next_per_en = next_bus_en &
    (~in_wait | config_reg[BIT_CFG_WAIT_ACT]);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus_clk_en <= 1'b0;
      clk_en     <= '0;
    end else begin
      bus_clk_en <= next_bus_en;
      clk_en     <= '{cpu: next_cpu_en, periph: next_per_en};
    end
  end

  // ----------------------------------------------------------------
  // External reset line, open drain, low during start-up
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reset_out  <= 1'b0;
      reset_oe_n <= 1'b0;
    end else begin
      reset_out  <= 1'b0;
      reset_oe_n <= next_state != ST_STARTUP;
    end
  end

  // ----------------------------------------------------------------
  // Reset cause register
  // ----------------------------------------------------------------
  // Power-on clears the others; later sources accumulate
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reset_cause <= 8'h80;
    end else if (reset_src.power_on) begin
      reset_cause <= 8'h80;
    end else begin
      reset_cause[BIT_PIN]         <= reset_cause[BIT_PIN] | reset_src.pin;
      reset_cause[BIT_WATCHDOG]    <= reset_cause[BIT_WATCHDOG]
                                      | reset_src.watchdog;
      reset_cause[BIT_BAD_OPCODE]  <= reset_cause[BIT_BAD_OPCODE]
                                      | reset_src.bad_opcode;
      reset_cause[BIT_BAD_ADDRESS] <= reset_cause[BIT_BAD_ADDRESS]
                                      | reset_src.bad_address;
      reset_cause[BIT_LOW_VOLTAGE] <= reset_cause[BIT_LOW_VOLTAGE]
                                      | reset_src.low_voltage;
    end
  end

  // ----------------------------------------------------------------
  // Break registers and configuration
  // ----------------------------------------------------------------
  // A break during wait wins over a software clear in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      break_wait   <= 1'b0;
      clear_enable <= 1'b0;
      config_reg   <= RESET_BYTE;
    end else begin
      if (break_event && in_wait) begin
        break_wait <= 1'b1;
      end else if (wr_lane0 && hit_brk && clear_enable
                   && !wr_byte[BIT_BREAK_WAIT]) begin
        break_wait <= 1'b0;
      end
      if (wr_lane0 && hit_ctl) begin
        clear_enable <= wr_byte[BIT_CLEAR_EN];
      end
      if (wr_lane0 && hit_cfg) begin
        config_reg <= wr_byte & CFG_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  wire [7:0] irq_set = {5'h00, |(reset_cause & CAUSE_MASK) & 1'b0,
                        state == ST_RECOVER && recover_done,
                        state == ST_STARTUP && startup_done};
  wire [7:0] irq_clr = (wr_lane0 && hit_ist) ? (wr_byte & IRQ_MASK) : 8'h00;

  // Write-one-to-clear; a new event in the same cycle stays set
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= 8'h00;
      irq_mask   <= 8'h00;
      irq_out    <= 1'b0;
      irq_pending <= 1'b0;
    end else begin
      irq_status  <= ((irq_status & ~irq_clr) | irq_set) & IRQ_MASK;
      if (wr_lane0 && hit_imk) begin
        irq_mask <= wr_byte & IRQ_MASK;
      end
      irq_out     <= |(irq_status & irq_mask);
      irq_pending <= any_irq;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone answer: one wait state, ack for one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? {24'h000000, rd_byte} : '0;
    end
  end

endmodule : system_clock_startup_control

// [verification/clk_ctrl_props_properties.sv]
/*
  Checker for the clock start-up control block: bus handshake, clock
  enable cadence, start-up reset line and register read-back fields.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
module clk_ctrl_props
  import clk_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic      mclk,
  input wire logic      arst_n,
  // Register bus
  input wire logic      wb_cyc_i,
  input wire logic      wb_stb_i,
  input wire logic      wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic      wb_ack_o,
  // Clock enables and pins
  input wire clk_en_s   clk_en,
  input wire logic      bus_clk_en,
  input wire logic      reset_out,
  input wire logic      reset_oe_n,
  input wire logic      irq_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Read strobe of the answer cycle; master holds the address until ack
  wire rd_ack = wb_ack_o && !wb_we_i;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack not one cycle after request");
  a_upper_zero: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_cause_fixed_zero: assert property (rd_ack && wb_adr_i == ADDR_RESET_CAUSE
    |-> !wb_dat_o[2] && !wb_dat_o[0])
    else $error("fixed cause bits not zero");
  a_status_reserved: assert property (rd_ack && wb_adr_i == ADDR_BREAK_STATUS
    |-> wb_dat_o[7:2] == 6'h0 && !wb_dat_o[0])
    else $error("reserved break status bits set");
  a_ctrl_reserved: assert property (rd_ack && wb_adr_i == ADDR_BREAK_CONTROL
    |-> wb_dat_o[6:0] == 7'h0)
    else $error("reserved break control bits set");
  a_bus_halves: assert property (bus_clk_en |=> !bus_clk_en)
    else $error("bus enable on two cycles in a row");
  a_one_source: assert property (clk_en.cpu || clk_en.periph
    |-> bus_clk_en)
    else $error("gated enable outside bus enable");
  a_line_low: assert property (reset_out == 1'b0)
    else $error("reset line driven high");
  a_clocks_held: assert property (!reset_oe_n |-> !bus_clk_en && !clk_en.cpu
    && !clk_en.periph)
    else $error("clock enable during start-up");
  a_start_prompt: assert property ($rose(reset_oe_n)
    |-> ##[1:2] bus_clk_en)
    else $error("bus clock late after start-up");
  // Main scenarios reached
  c_read: cover property (rd_ack);
  c_start: cover property ($rose(reset_oe_n));
  c_irq: cover property ($rose(irq_out));
endmodule : clk_ctrl_props

// [verification/ref_osc_model.sv]
/*
  Reference oscillator model on the far side: one tick per falling edge
  of the reference clock, one every fourth mclk, and a tally for timing.
  Assumes mclk and arst_n of the bench.
*/
`timescale 1ns/10ps
module ref_osc_model (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // Tick toward the block, tally toward the bench
  output logic      osc_ref_tick,
  output int        tick_count
);
  logic [1:0] phase;
  wire        edge_now = (phase == 2'h3);
  // Tally rises with the tick so the bench can read elapsed ticks
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 2'h0;
      osc_ref_tick <= 1'b0;
      tick_count <= 0;
    end else begin
      phase <= phase + 2'h1;
      osc_ref_tick <= edge_now;
      tick_count <= tick_count + int'(edge_now);
    end
  end
endmodule : ref_osc_model

// [verification/system_clock_startup_control_tb.sv]
/*
  Bench for the clock start-up control block: start-up, registers, bus
  rate, wait, stop recovery, interrupt and reset cause scenarios.
  Assumes a shortened start-up count of 16 reference ticks.
*/
`timescale 1ns/10ps
module system_clock_startup_control_tb;
  import clk_ctrl_pkg::*;
  logic mclk = 1'b0, arst_n = 1'b0, stop_req = 1'b0, wait_req = 1'b0;
  logic wake_event = 1'b0, break_event = 1'b0, wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0;
  logic [31:0] wb_dat_i = 32'h0, irq_sources = 32'h0, wb_dat_o;
  reset_src_s rsrc = '0;
  clk_en_s clk_en;
  logic wb_ack_o, bus_clk_en, reset_out, reset_oe_n, irq_pending, irq_out;
  logic osc_ref_tick;
  int tick_count, bad_count = 0, comparisons = 0;

  always #5 mclk = ~mclk;
  ref_osc_model osc (.mclk(mclk), .arst_n(arst_n),
    .osc_ref_tick(osc_ref_tick), .tick_count(tick_count));
  system_clock_startup_control #(.STARTUP_CYCLES(16)) dut (
    .mclk(mclk), .arst_n(arst_n), .osc_ref_tick(osc_ref_tick),
    .reset_src(rsrc), .stop_req(stop_req), .wait_req(wait_req),
    .wake_event(wake_event), .break_event(break_event),
    .irq_sources(irq_sources), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .clk_en(clk_en), .bus_clk_en(bus_clk_en), .reset_out(reset_out),
    .reset_oe_n(reset_oe_n), .irq_pending(irq_pending), .irq_out(irq_out));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  // One classic cycle; waits on ack, takes data at that same edge
  task xfer(input logic [15:0] a, input logic w, input logic [7:0] d,
            output logic [7:0] q);
    int n;
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'b11, w, a};
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) bad_count++;
    q = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask : xfer
  task wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(a, 1'b1, d, q);
  endtask : wr
  task rd_chk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] q;
    xfer(a, 1'b0, 8'h0, q);
    check({24'h0, q}, {24'h0, exp});
  endtask : rd_chk
  // Tally enables over n settled cycles
  task count_en(input int n, output int b, output int c, output int p);
    b = 0;
    c = 0;
    p = 0;
    repeat (2) @(posedge mclk);
    repeat (n) begin
      @(negedge mclk);
      b += int'(bus_clk_en === 1'b1);
      c += int'(clk_en.cpu === 1'b1);
      p += int'(clk_en.periph === 1'b1);
    end
  endtask : count_en
  task t_startup;
    int n;
    for (n = 0; n < 300 && tick_count < 15; n++) @(negedge mclk);
    check(reset_oe_n, 1'b0);
    check(bus_clk_en, 1'b0);
    for (n = 0; n < 40 && reset_oe_n !== 1'b1; n++) @(negedge mclk);
    check(tick_count, 16);
    rd_chk(ADDR_RESET_CAUSE, 8'h80);
    $display("startup done");
  endtask : t_startup
  task t_regs;
    rd_chk(ADDR_BREAK_STATUS, 8'h00);
    wr(ADDR_BREAK_CONTROL, 8'hff);
    rd_chk(ADDR_BREAK_CONTROL, 8'h80);
    wr(ADDR_RESET_CAUSE, 8'h7f);
    rd_chk(ADDR_RESET_CAUSE, 8'h80);
    rd_chk(16'hfe02, 8'h00);
    wr(ADDR_BREAK_CONTROL, 8'h00);
    $display("registers done");
  endtask : t_regs
  // Wait with peripherals off, then kept on; a break ends the second
  task t_wait;
    int b, c, p;
    count_en(40, b, c, p);
    check(b, 20);
    check(c + p, 40);
    wr(ADDR_CONFIG, 8'h00);
    @(posedge mclk) wait_req <= 1'b1;
    @(posedge mclk) wait_req <= 1'b0;
    count_en(20, b, c, p);
    check(c + p, 0);
    @(posedge mclk) wake_event <= 1'b1;
    @(posedge mclk) wake_event <= 1'b0;
    wr(ADDR_CONFIG, 8'h02);
    @(posedge mclk) wait_req <= 1'b1;
    @(posedge mclk) wait_req <= 1'b0;
    count_en(20, b, c, p);
    check(c, 0);
    check(p, 10);
    @(posedge mclk) break_event <= 1'b1;
    @(posedge mclk) break_event <= 1'b0;
    rd_chk(ADDR_BREAK_STATUS, 8'h02);
    wr(ADDR_BREAK_STATUS, 8'h00);
    rd_chk(ADDR_BREAK_STATUS, 8'h02);
    wr(ADDR_BREAK_CONTROL, 8'h80);
    wr(ADDR_BREAK_STATUS, 8'h00);
    rd_chk(ADDR_BREAK_STATUS, 8'h00);
    wr(ADDR_BREAK_CONTROL, 8'h00);
    count_en(20, b, c, p);
    check(c, 10);
    $display("wait done");
  endtask : t_wait
  // Stop, wake by event (short) or by interrupt line (long), time it
  task t_stop(input logic short, input int exp);
    int b, c, p, t0, n;
    wr(ADDR_CONFIG, {7'h0, short});
    @(posedge mclk) stop_req <= 1'b1;
    @(posedge mclk) stop_req <= 1'b0;
    count_en(12, b, c, p);
    check(b + c + p, 0);
    t0 = tick_count;
    @(posedge mclk);
    if (short) wake_event <= 1'b1;
    else irq_sources <= 32'h1;
    @(posedge mclk) {wake_event, irq_sources} <= 33'h0;
    for (n = 0; n < 20000 && bus_clk_en !== 1'b1; n++) @(negedge mclk);
    n = tick_count - t0;
    check(n >= exp - 1 && n <= exp + 1, 1'b1);
    $display("stop recovery done");
  endtask : t_stop
  // Raise, mask and clear the event interrupt
  task t_irq;
    rd_chk(ADDR_IRQ_STATUS, 8'h03);
    wr(ADDR_IRQ_MASK, 8'h02);
    repeat (2) @(posedge mclk);
    check(irq_out, 1'b1);
    wr(ADDR_IRQ_STATUS, 8'h02);
    repeat (2) @(posedge mclk);
    check(irq_out, 1'b0);
    rd_chk(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h00);
    @(posedge mclk) rsrc.watchdog <= 1'b1;
    @(posedge mclk) rsrc.watchdog <= 1'b0;
    rd_chk(ADDR_RESET_CAUSE, 8'ha0);
    @(posedge mclk) {rsrc.pin, rsrc.bad_opcode, rsrc.bad_address} <= 3'h7;
    @(posedge mclk) {rsrc.pin, rsrc.bad_opcode, rsrc.bad_address} <= 3'h0;
    rd_chk(ADDR_RESET_CAUSE, 8'hf8);
    @(posedge mclk) irq_sources <= 32'h80000000;
    repeat (3) @(posedge mclk);
    check(irq_pending, 1'b1);
    irq_sources <= 32'h0;
    $display("interrupt and cause done");
  endtask : t_irq
  // Low-voltage reset in run restarts the start-up timeout
  task t_lvi;
    int n;
    @(posedge mclk) rsrc.low_voltage <= 1'b1;
    @(posedge mclk) rsrc.low_voltage <= 1'b0;
    @(negedge mclk);
    check(reset_oe_n, 1'b0);
    check(bus_clk_en, 1'b0);
    for (n = 0; n < 300 && reset_oe_n !== 1'b1; n++) @(negedge mclk);
    check(reset_oe_n, 1'b1);
    rd_chk(ADDR_RESET_CAUSE, 8'hfa);
    $display("low voltage restart done");
  endtask : t_lvi
  task finish_test;
    $display("compares %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    t_startup();
    t_regs();
    t_wait();
    t_stop(1'b1, 32);
    t_stop(1'b0, 4096);
    t_irq();
    t_lvi();
    finish_test();
  end
  // Long stop recovery dominates; about two and a half times its length is allowed
  initial begin
    #400000;
    bad_count++;
    finish_test();
  end
endmodule : system_clock_startup_control_tb

bind system_clock_startup_control clk_ctrl_props props (.mclk(mclk),
  .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .clk_en(clk_en), .bus_clk_en(bus_clk_en),
  .reset_out(reset_out), .reset_oe_n(reset_oe_n), .irq_out(irq_out));
